// file: hw/mdrsb_status_bank.v
// Read-only status register bank of a motion drive.
`timescale 1ns/1ns
`include "mdrsb_map.vh"

module mdrsb_status_bank #(
   parameter CLEANUP_CYCLES = `MDRSB_CLEANUP_CYC
) (
   input wire clk,
   input wire nrst,
   input wire [1:0] variantSel,
   input wire programmable,
   // Host serial command port.
   input wire uploadReq,
   input wire byLetter,
   input wire [7:0] regCode,
   input wire loadReq,
   output reg [31:0] uploadData,
   output reg uploadLong,
   output reg uploadValid,
   output reg uploadError,
   output reg loadIgnored,
   // Host commands that set positions.
   input wire setEncoderCountCmd,
   input wire [31:0] setEncoderValue,
   input wire setPositionCmd,
   input wire [31:0] setPositionValue,
   // Drive core values, same clock.
   input wire [15:0] analogCmdRaw,
   input wire [15:0] analogOffsetCmd,
   input wire [5:0] programLine,
   input wire [15:0] currentCmd,
   input wire [31:0] faultCode,
   input wire [15:0] analogInOneRaw,
   input wire [15:0] analogInTwoRaw,
   input wire [15:0] operatingModeCmd,
   input wire [15:0] positioningState,
   input wire [3:0] outputClosed,
   input wire motorStep,
   input wire motorDir,
   input wire relMoveStart,
   input wire relMoveDone,
   input wire sensorMoveActive,
   input wire condStrobe,
   input wire [31:0] condFirst,
   input wire [31:0] condSecond,
   input wire jogStart,
   input wire jogFastStop,
   input wire jogStop,
   input wire jogStopped,
   // Drive pins, asynchronous.
   input wire encA,
   input wire encB,
   input wire indexInput,
   input wire sensorInput,
   input wire [7:0] inputOpen,
   input wire stepInput,
   input wire dirInput,
   input wire enableInput,
   output wire [2:0] jogState
);

   // ========================================
   // Pin synchronisers
   // ========================================
   wire [14:0] pinRaw;
   reg [14:0] pinMeta;
   reg [14:0] pinSync;
   reg [14:0] pinLast;
   assign pinRaw = {enableInput, dirInput, stepInput, inputOpen, sensorInput, indexInput,
                    encB, encA};

   // Two flip-flops before any logic, then a history stage for edges.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pinMeta <= 15'h0000;
         pinSync <= 15'h0000;
         pinLast <= 15'h0000;
      end else begin
         pinMeta <= pinRaw;
         pinSync <= pinMeta;
         pinLast <= pinSync;
      end
   end

   wire sIndex = pinSync[2];
   wire [7:0] sIn = pinSync[11:4];
   wire sStep = pinSync[12];
   wire sDir = pinSync[13];
   wire sEn = pinSync[14];

   // ========================================
   // Absolute position, relative distance, sensor capture
   // ========================================
   reg [31:0] absPos;
   reg [31:0] moveStartPos;
   reg [31:0] relDist;
   reg moveActive;
   reg [15:0] sensorPos;
   // Next position, distance so far and the synchronised sensor edge.
   wire [31:0] next_absPos = motorStep ? (motorDir ? absPos - 32'h0000_0001 :
                             absPos + 32'h0000_0001) : absPos;
   wire [31:0] travelled = next_absPos - moveStartPos;
   wire continuousVariant = (variantSel != `MDRSB_VAR_GROUP_ONE);
   wire sensorEdge = pinSync[3] & ~pinLast[3];

   // Position counts steps; a host set overrides a step in the same cycle.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         absPos <= 32'h0000_0000;
         moveStartPos <= 32'h0000_0000;
         relDist <= 32'h0000_0000;
         moveActive <= 1'b0;
         sensorPos <= 16'h0000;
      end else begin
         absPos <= setPositionCmd ? setPositionValue : next_absPos;
         if (relMoveStart) begin
            moveStartPos <= absPos;
            moveActive <= 1'b1;
            if (continuousVariant) begin
               relDist <= 32'h0000_0000;
            end
         end else if (moveActive) begin
            if (continuousVariant) begin
               relDist <= travelled;
            end
            if (relMoveDone) begin
               moveActive <= 1'b0;
               relDist <= travelled;
            end
         end
         if (sensorMoveActive && sensorEdge) begin
            sensorPos <= absPos[15:0];
         end
      end
   end

   // ========================================
   // Quadrature encoder counter
   // ========================================
   reg [31:0] encCount;
   // One phase change is one count; up when new A differs from old B.
   wire encStep = (pinSync[0] ^ pinLast[0]) ^ (pinSync[1] ^ pinLast[1]);
   wire encUp = pinSync[0] ^ pinLast[1];

   // A set command, such as zero, wins over a count in the same cycle.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         encCount <= 32'h0000_0000;
      end else if (setEncoderCountCmd) begin
         encCount <= setEncoderValue;
      end else if (encStep) begin
         encCount <= encUp ? encCount + 32'h0000_0001 : encCount - 32'h0000_0001;
      end
   end

   // ========================================
   // Condition flags
   // ========================================
   reg [7:0] condFlags;
   reg [7:0] next_condFlags;

   // Compare the first value with zero and with the second value.
   always @* begin
      next_condFlags = 8'h00;
      next_condFlags[`MDRSB_COND_TRUE] = (condFirst != 32'h0000_0000);
      next_condFlags[`MDRSB_COND_ZERO] = (condFirst == 32'h0000_0000);
      next_condFlags[`MDRSB_COND_POS] = ~condFirst[31] & (condFirst != 32'h0000_0000);
      next_condFlags[`MDRSB_COND_NEG] = condFirst[31];
      next_condFlags[`MDRSB_COND_GT] = $signed(condFirst) > $signed(condSecond);
      next_condFlags[`MDRSB_COND_LT] = $signed(condFirst) < $signed(condSecond);
      next_condFlags[`MDRSB_COND_EQ] = (condFirst == condSecond);
      next_condFlags[`MDRSB_COND_NE] = (condFirst != condSecond);
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         condFlags <= 8'h00;
      end else if (condStrobe) begin
         condFlags <= next_condFlags;
      end
   end

   // ========================================
   // Packed I/O word per variant
   // ========================================
   reg [15:0] ioWord;

   // Input bits are the pin level (one means open); outputs are one when closed.
   always @* begin
      ioWord = 16'h0000;
      case (variantSel)
         `MDRSB_VAR_GROUP_ONE: begin
            ioWord[0] = sIndex;
            ioWord[7:1] = sIn[6:0];
            ioWord[10:8] = outputClosed[2:0];
         end
         `MDRSB_VAR_GROUP_TWO: begin
            ioWord[7:0] = sIn;
            ioWord[11:8] = outputClosed;
            ioWord[12] = sIndex;
         end
         `MDRSB_VAR_SMALL: begin
            ioWord[0] = sIndex;
            ioWord[1] = sStep;
            ioWord[2] = sDir;
            ioWord[3] = sEn;
            ioWord[8] = outputClosed[0];
         end
         default: begin
            ioWord[3:0] = sIn[3:0];
            ioWord[9:8] = outputClosed[1:0];
            ioWord[14] = sIndex;
         end
      endcase
   end

   // ========================================
   // Jog motion state machine
   // ========================================
   localparam [31:0] CLEAN_LAST_FULL = CLEANUP_CYCLES - 1;
   localparam [12:0] CLEAN_LAST = CLEAN_LAST_FULL[12:0];
   reg [2:0] jogCur;
   reg [2:0] next_jogCur;
   reg [12:0] cleanCount;
   assign jogState = jogCur;

   always @* begin
      next_jogCur = jogCur;
      case (jogCur)
         `MDRSB_JOG_WAIT: begin
            if (jogStart) begin
               next_jogCur = `MDRSB_JOG_RUN;
            end
         end
         `MDRSB_JOG_RUN: begin
            if (jogFastStop) begin
               next_jogCur = `MDRSB_JOG_FAST;
            end else if (jogStop) begin
               next_jogCur = `MDRSB_JOG_STOP;
            end
         end
         `MDRSB_JOG_FAST, `MDRSB_JOG_STOP: begin
            if (jogStopped) begin
               next_jogCur = `MDRSB_JOG_CLEAN;
            end
         end
         `MDRSB_JOG_CLEAN: begin
            if (cleanCount == CLEAN_LAST) begin
               next_jogCur = `MDRSB_JOG_WAIT;
            end
         end
         default: begin
            next_jogCur = `MDRSB_JOG_WAIT;
         end
      endcase
   end

   // Cleanup counter runs only inside the cleanup state.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         jogCur <= `MDRSB_JOG_WAIT;
         cleanCount <= 13'h0000;
      end else begin
         jogCur <= next_jogCur;
         cleanCount <= (jogCur == `MDRSB_JOG_CLEAN) ? cleanCount + 13'h0001 : 13'h0000;
      end
   end

   // ========================================
   // Host upload port
   // ========================================
   wire [7:0] regIndex;
   wire [15:0] analogCmd;
   reg [31:0] selValue;
   reg selLong;
   reg selHit;

   assign regIndex = byLetter ? (regCode - `MDRSB_LETTER_FIRST + `MDRSB_IDX_ANALOG_CMD) :
                     regCode;
   assign analogCmd = analogCmdRaw + analogOffsetCmd;

   always @* begin
      selValue = 32'h0000_0000;
      selLong = 1'b0;
      selHit = 1'b1;
      if (byLetter && (regCode < `MDRSB_LETTER_FIRST || regCode > `MDRSB_LETTER_LAST)) begin
         selHit = 1'b0;
      end else begin
         case (regIndex)
            `MDRSB_IDX_ANALOG_CMD: selValue[15:0] = analogCmd;
            `MDRSB_IDX_PROG_LINE: selValue[5:0] = programmable ? programLine : 6'h00;
            `MDRSB_IDX_CURRENT_CMD: selValue[15:0] = currentCmd;
            `MDRSB_IDX_REL_DIST: begin
               selValue = relDist;
               selLong = 1'b1;
            end
            `MDRSB_IDX_ENCODER: begin
               selValue = encCount;
               selLong = 1'b1;
            end
            `MDRSB_IDX_FAULT: begin
               selValue = faultCode;
               selLong = 1'b1;
            end
            `MDRSB_IDX_SENSOR_POS: selValue[15:0] = sensorPos;
            `MDRSB_IDX_COND: selValue[7:0] = condFlags;
            `MDRSB_IDX_IO: selValue[15:0] = ioWord;
            `MDRSB_IDX_AIN_ONE: selValue[15:0] = analogInOneRaw;
            `MDRSB_IDX_AIN_TWO: selValue[15:0] = analogInTwoRaw;
            `MDRSB_IDX_ABS_POS: begin
               selValue = absPos;
               selLong = 1'b1;
            end
            `MDRSB_IDX_MODE: selValue[15:0] = operatingModeCmd;
            `MDRSB_IDX_JOG_STATE: selValue[2:0] = jogCur;
            `MDRSB_IDX_P2P_STATE: selValue[15:0] = positioningState;
            default: selHit = 1'b0;
         endcase
      end
   end

   // One snapshot per upload; data stands until the next upload.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         uploadData <= 32'h0000_0000;
         uploadLong <= 1'b0;
         uploadValid <= 1'b0;
         uploadError <= 1'b0;
         loadIgnored <= 1'b0;
      end else begin
         uploadValid <= uploadReq & selHit;
         uploadError <= uploadReq & ~selHit;
         loadIgnored <= loadReq & selHit;
         if (uploadReq) begin
            uploadData <= selHit ? selValue : 32'h0000_0000;
            uploadLong <= selHit & selLong;
         end
      end
   end

endmodule // mdrsb_status_bank

// file: include/mdrsb_map.vh
// Constants of the motion drive read-only status register bank.
//
// Function
// - Analog command scaled signed sixteen bits.
// - Analog command includes configured offset.
// - Program line sixteen bits, lines 1-62.
// - Current command in 0.01 ampere units.
// - Group one: distance updated at move end.
// - Group two: distance tracks during move.
// - Encoder count cleared by set command zero.
// - Fault register is 32-bit code word.
// - Sensor position captured at input condition.
// - Absolute position zero at every power-up.
// - Condition bit n weighs two to n.
// - False shown by condition bit zero clear.
// - Group one I/O: index, inputs, three outputs.
// - Input bit one open; output one closed.
// - Group two I/O: inputs, four outputs, index 12.
// - Small I/O: index, step, dir, enable, out.
// - Remaining I/O: four inputs, two outputs, index 14.
// - Analog inputs raw counts 0 to 32760.
// - Jog state codes zero through four.
// - Cleanup state lasts one 62 us cycle.
// - Short registers 16 bits, long 32.
// - Loads into read-only registers are ignored.
`ifndef MDRSB_MAP_VH
`define MDRSB_MAP_VH

// Numeric register indices, first letter code and last letter code.
`define MDRSB_IDX_ANALOG_CMD 8'h31
`define MDRSB_IDX_PROG_LINE 8'h32
`define MDRSB_IDX_CURRENT_CMD 8'h33
`define MDRSB_IDX_REL_DIST 8'h34
`define MDRSB_IDX_ENCODER 8'h35
`define MDRSB_IDX_FAULT 8'h36
`define MDRSB_IDX_SENSOR_POS 8'h37
`define MDRSB_IDX_COND 8'h38
`define MDRSB_IDX_IO 8'h39
`define MDRSB_IDX_AIN_ONE 8'h3a
`define MDRSB_IDX_AIN_TWO 8'h3b
`define MDRSB_IDX_ABS_POS 8'h3c
`define MDRSB_IDX_MODE 8'h3d
`define MDRSB_IDX_JOG_STATE 8'h3e
`define MDRSB_IDX_P2P_STATE 8'h3f
`define MDRSB_LETTER_FIRST 8'h61
`define MDRSB_LETTER_LAST 8'h6f

// Condition flag bit positions.
`define MDRSB_COND_TRUE 0
`define MDRSB_COND_ZERO 1
`define MDRSB_COND_POS 2
`define MDRSB_COND_NEG 3
`define MDRSB_COND_GT 4
`define MDRSB_COND_LT 5
`define MDRSB_COND_EQ 6
`define MDRSB_COND_NE 7

// Drive variant codes.
`define MDRSB_VAR_GROUP_ONE 2'h0
`define MDRSB_VAR_GROUP_TWO 2'h1
`define MDRSB_VAR_SMALL 2'h2
`define MDRSB_VAR_REMAIN 2'h3

// Jog state codes.
`define MDRSB_JOG_WAIT 3'h0
`define MDRSB_JOG_RUN 3'h1
`define MDRSB_JOG_FAST 3'h2
`define MDRSB_JOG_STOP 3'h3
`define MDRSB_JOG_CLEAN 3'h4

// Timing: clock rate and cleanup time.
`define MDRSB_CLK_MHZ 100
`define MDRSB_CLEANUP_NS 62000
`define MDRSB_CLEANUP_CYC ((`MDRSB_CLEANUP_NS * `MDRSB_CLK_MHZ) / 1000)

`endif

// file: test/mdrsb_status_bank_chk.sv
// Concurrent checks on the status bank ports.
`timescale 1ns/1ns
module mdrsb_status_bank_chk #(
   parameter CLEANUP_CYCLES = 8
) (
   input wire clk,
   input wire nrst,
   input wire byLetter,
   input wire [7:0] regCode,
   input wire uploadReq,
   input wire loadReq,
   input wire [31:0] uploadData,
   input wire uploadLong,
   input wire uploadValid,
   input wire uploadError,
   input wire loadIgnored,
   input wire jogStart,
   input wire jogFastStop,
   input wire jogStop,
   input wire jogStopped,
   input wire [2:0] jogState
);
   // Decode of mapped codes and of the long registers.
   wire mapped = byLetter ? (regCode >= 8'h61 && regCode <= 8'h6f) :
      (regCode >= 8'h31 && regCode <= 8'h3f);
   wire isLong = mapped && (regCode[3:0] == 4'h4 || regCode[3:0] == 4'h5 ||
      regCode[3:0] == 4'h6 || regCode[3:0] == 4'hc);
   reg [31:0] cleanCnt;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Counts the cycles spent in the cleanup state.
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cleanCnt <= 32'h0000_0000;
      end else begin
         cleanCnt <= (jogState == 3'h4) ? cleanCnt + 32'h0000_0001 : 32'h0000_0000;
      end
   end
   AST_UPOK: assert property (uploadReq && mapped |=> uploadValid && !uploadError)
      else $error("mapped upload not answered");
   AST_UPERR: assert property (uploadReq && !mapped |=> uploadError && !uploadValid &&
      uploadData == 32'h0000_0000) else $error("unmapped upload not refused");
   AST_LONG: assert property (uploadReq && mapped |=> uploadLong == $past(isLong) &&
      ($past(isLong) || uploadData[31:16] == 16'h0000)) else $error("word width wrong");
   AST_LOAD: assert property (loadReq && mapped |=> loadIgnored)
      else $error("load not reported ignored");
   AST_STAND: assert property (!uploadReq |=> $stable(uploadData) && $stable(uploadLong))
      else $error("upload data changed without request");
   AST_JOGRUN: assert property (jogState == 3'h0 && jogStart |=> jogState == 3'h1)
      else $error("jog start missed");
   AST_JOGFAST: assert property (jogState == 3'h1 && jogFastStop |=> jogState == 3'h2)
      else $error("fast stop missed");
   AST_JOGSTOP: assert property (jogState == 3'h1 && jogStop && !jogFastStop
      |=> jogState == 3'h3) else $error("normal stop missed");
   AST_JOGEND: assert property ((jogState == 3'h2 || jogState == 3'h3) && jogStopped
      |=> jogState == 3'h4) else $error("cleanup not entered");
   AST_CLEANLEN: assert property ($fell(jogState == 3'h4) |->
      cleanCnt == CLEANUP_CYCLES && jogState == 3'h0) else $error("cleanup length wrong");
endmodule // mdrsb_status_bank_chk

// file: test/mdrsb_host_model.sv
// Host model that uploads and loads registers over the command port.
`timescale 1ns/1ns
module mdrsb_host_model (
   input wire clk,
   output reg uploadReq,
   output reg byLetter,
   output reg [7:0] regCode,
   output reg loadReq,
   input wire [31:0] uploadData,
   input wire uploadValid,
   input wire uploadError,
   input wire loadIgnored
);
   // Idle command port at time zero.
   initial begin
      uploadReq = 1'b0;
      loadReq = 1'b0;
      byLetter = 1'b0;
      regCode = 8'h00;
   end
   task upload(input lt, input [7:0] code, output [31:0] d, output v, output e);
      begin
         @(posedge clk);
         #1;
         uploadReq = 1'b1;
         byLetter = lt;
         regCode = code;
         @(posedge clk);
         #1;
         d = uploadData;
         v = uploadValid;
         e = uploadError;
         uploadReq = 1'b0;
         regCode = ~code;
      end
   endtask
   // Load attempt; the answer is the ignored pulse.
   task load(input [7:0] code, output ig);
      begin
         @(posedge clk);
         #1;
         loadReq = 1'b1;
         byLetter = 1'b0;
         regCode = code;
         @(posedge clk);
         #1;
         ig = loadIgnored;
         loadReq = 1'b0;
         regCode = ~code;
      end
   endtask
endmodule // mdrsb_host_model

// file: test/testbench.sv
// Self-checking bench of the status register bank.
`timescale 1ns/1ns
module testbench;
   reg clk, nrst, programmable, setEncoderCountCmd, setPositionCmd, motorStep, motorDir;
   reg relMoveStart, relMoveDone, sensorMoveActive, condStrobe, jogStart, jogFastStop;
   reg jogStop, jogStopped, encA, encB, indexInput, sensorInput, stepInput, dirInput;
   reg enableInput, v, e;
   reg [1:0] variantSel;
   reg [3:0] outputClosed;
   reg [5:0] programLine;
   reg [7:0] inputOpen;
   reg [15:0] analogCmdRaw, analogOffsetCmd, currentCmd, analogInOneRaw, analogInTwoRaw;
   reg [15:0] operatingModeCmd, positioningState;
   reg [31:0] setEncoderValue, setPositionValue, faultCode, condFirst, condSecond, d;
   wire [31:0] uploadData;
   wire [7:0] regCode;
   wire [2:0] jogState;
   wire uploadReq, byLetter, loadReq, uploadLong, uploadValid, uploadError, loadIgnored;
   integer failures, testsRun, i;
   // Clock of 10 ns.
   always #5 clk = ~clk;
   mdrsb_status_bank #(.CLEANUP_CYCLES(8)) DUT (.clk, .nrst, .variantSel, .programmable,
      .uploadReq, .byLetter, .regCode, .loadReq, .uploadData, .uploadLong, .uploadValid,
      .uploadError, .loadIgnored, .setEncoderCountCmd, .setEncoderValue, .setPositionCmd,
      .setPositionValue, .analogCmdRaw, .analogOffsetCmd, .programLine, .currentCmd,
      .faultCode, .analogInOneRaw, .analogInTwoRaw, .operatingModeCmd, .positioningState,
      .outputClosed, .motorStep, .motorDir, .relMoveStart, .relMoveDone, .sensorMoveActive,
      .condStrobe, .condFirst, .condSecond, .jogStart, .jogFastStop, .jogStop, .jogStopped,
      .encA, .encB, .indexInput, .sensorInput, .inputOpen, .stepInput, .dirInput,
      .enableInput, .jogState);
   mdrsb_host_model host (.clk, .uploadReq, .byLetter, .regCode, .loadReq, .uploadData,
      .uploadValid, .uploadError, .loadIgnored);
   // ========
   // Helpers
   task tick;
      begin
         @(posedge clk);
         #1;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         testsRun = testsRun + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Uploads one register and compares its value.
   task rd(input lt, input [7:0] code, input [31:0] exp);
      begin
         host.upload(lt, code, d, v, e);
         chk({31'h0000_0000, v}, 32'h0000_0001);
         chk(d, exp);
      end
   endtask
   task steps(input integer n, input dn);
      begin
         motorDir = dn;
         repeat (n) begin
            motorStep = 1'b1;
            tick;
            motorStep = 1'b0;
            tick;
         end
      end
   endtask
   // ========
   // Scenarios
   task t_plain;
      begin
         rd(0, 8'h3c, 32'h0000_0000);
         analogCmdRaw = 16'h7ff0;
         analogOffsetCmd = 16'h0008;
         programLine = 6'h3e;
         programmable = 1'b1;
         currentCmd = 16'h00c8;
         faultCode = 32'h8000_0101;
         analogInOneRaw = 16'h3fff;
         analogInTwoRaw = 16'h7ff8;
         operatingModeCmd = 16'h0015;
         rd(0, 8'h31, 32'h0000_7ff8);
         rd(1, 8'h62, 32'h0000_003e);
         rd(0, 8'h33, 32'h0000_00c8);
         rd(1, 8'h66, 32'h8000_0101);
         rd(0, 8'h3a, 32'h0000_3fff);
         rd(1, 8'h6b, 32'h0000_7ff8);
         rd(1, 8'h6d, 32'h0000_0015);
         analogCmdRaw = 16'h8000;
         positioningState = 16'h0007;
         rd(1, 8'h61, 32'h0000_8008);
         rd(1, 8'h6f, 32'h0000_0007);
         programmable = 1'b0;
         rd(0, 8'h32, 32'h0000_0000);
         $display("test plain done");
      end
   endtask
   task t_enc;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            encA = ~i[1];
            encB = i[1] ^ i[0];
            repeat (3) tick;
         end
         rd(0, 8'h35, 32'h0000_0008);
         setEncoderCountCmd = 1'b1;
         tick;
         setEncoderCountCmd = 1'b0;
         rd(1, 8'h65, 32'h0000_0000);
         host.load(8'h35, v);
         chk({31'h0000_0000, v}, 32'h0000_0001);
         rd(0, 8'h35, 32'h0000_0000);
         host.upload(0, 8'h40, d, v, e);
         chk({31'h0000_0000, e}, 32'h0000_0001);
         chk(d, 32'h0000_0000);
         host.upload(1, 8'h70, d, v, e);
         chk({31'h0000_0000, e}, 32'h0000_0001);
         $display("test encoder done");
      end
   endtask
   task t_rel;
      begin
         relMoveStart = 1'b1;
         tick;
         relMoveStart = 1'b0;
         steps(5, 1'b0);
         rd(0, 8'h34, 32'h0000_0000);
         relMoveDone = 1'b1;
         tick;
         relMoveDone = 1'b0;
         rd(0, 8'h34, 32'h0000_0005);
         variantSel = 2'h1;
         relMoveStart = 1'b1;
         tick;
         relMoveStart = 1'b0;
         steps(3, 1'b1);
         rd(1, 8'h64, 32'hffff_fffd);
         rd(1, 8'h6c, 32'h0000_0002);
         relMoveDone = 1'b1;
         sensorMoveActive = 1'b1;
         setPositionValue = 32'h0001_2345;
         setPositionCmd = 1'b1;
         tick;
         relMoveDone = 1'b0;
         setPositionCmd = 1'b0;
         sensorInput = 1'b1;
         repeat (4) tick;
         sensorMoveActive = 1'b0;
         rd(0, 8'h37, 32'h0000_2345);
         $display("test motion done");
      end
   endtask
   task t_cond(input [31:0] a, input [31:0] b, input [31:0] exp);
      begin
         condFirst = a;
         condSecond = b;
         condStrobe = 1'b1;
         tick;
         condStrobe = 1'b0;
         rd(1, 8'h68, exp);
         $display("test condition done");
      end
   endtask
   task t_io;
      begin
         inputOpen = 8'ha5;
         outputClosed = 4'h6;
         {indexInput, stepInput, dirInput, enableInput} = 4'hb;
         repeat (3) tick;
         variantSel = 2'h0;
         rd(0, 8'h39, 32'h0000_064b);
         variantSel = 2'h1;
         rd(0, 8'h39, 32'h0000_16a5);
         variantSel = 2'h2;
         rd(0, 8'h39, 32'h0000_000d);
         variantSel = 2'h3;
         rd(0, 8'h39, 32'h0000_4205);
         $display("test io done");
      end
   endtask
   task t_jog;
      begin
         jogStart = 1'b1;
         tick;
         jogStart = 1'b0;
         chk({29'h0000_0000, jogState}, 32'h0000_0001);
         jogFastStop = 1'b1;
         tick;
         jogFastStop = 1'b0;
         chk({29'h0000_0000, jogState}, 32'h0000_0002);
         jogStopped = 1'b1;
         tick;
         jogStopped = 1'b0;
         repeat (7) tick;
         chk({29'h0000_0000, jogState}, 32'h0000_0004);
         tick;
         chk({29'h0000_0000, jogState}, 32'h0000_0000);
         jogStart = 1'b1;
         tick;
         jogStart = 1'b0;
         jogStop = 1'b1;
         tick;
         jogStop = 1'b0;
         rd(0, 8'h3e, 32'h0000_0003);
         $display("test jog done");
      end
   endtask
   task finalReport;
      begin
         $display("comparisons %0d mismatches %0d", testsRun, failures);
         if (failures == 0 && testsRun > 0) begin
            $display("Result: passed");
         end else begin
            $display("Result: failed");
         end
         $finish;
      end
   endtask
   // Main sequence after an eight cycle reset.
   initial begin
      {nrst, programmable, setEncoderCountCmd, setPositionCmd, motorStep, motorDir,
         relMoveStart, relMoveDone, sensorMoveActive, condStrobe, jogStart, jogFastStop,
         jogStop, jogStopped, encA, encB, indexInput, sensorInput, stepInput, dirInput,
         enableInput, variantSel, outputClosed, programLine, inputOpen, analogCmdRaw,
         analogOffsetCmd, currentCmd, analogInOneRaw, analogInTwoRaw, operatingModeCmd,
         positioningState, setEncoderValue, setPositionValue, faultCode, condFirst,
         condSecond} = '0;
      clk = 1'b0;
      failures = 0;
      testsRun = 0;
      repeat (8) @(posedge clk);
      #1;
      nrst = 1'b1;
      t_plain;
      t_enc;
      t_rel;
      t_cond(32'h0000_0005, 32'h0000_0003, 32'h0000_0095);
      t_cond(32'h0000_0000, 32'h0000_0000, 32'h0000_0042);
      t_cond(32'hffff_ffff, 32'h0000_0000, 32'h0000_00a9);
      t_io;
      t_jog;
      finalReport;
   end
   // Watchdog well beyond the fewer than two hundred cycles the tests need.
   initial begin
      #50000;
      failures = failures + 1;
      finalReport;
   end
endmodule // testbench
bind mdrsb_status_bank mdrsb_status_bank_chk #(.CLEANUP_CYCLES(CLEANUP_CYCLES)) chk (.clk,
   .nrst, .byLetter, .regCode, .uploadReq, .loadReq, .uploadData, .uploadLong, .uploadValid,
   .uploadError, .loadIgnored, .jogStart, .jogFastStop, .jogStop, .jogStopped, .jogState);
